// file: rtl/ocs_params.svh
// Offsets, field positions, reset values and timing counts
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

`define CLK_HZ             64'd50000000
`define FORCE_TIMEOUT_MIN  64'd5
`define FORCE_TIMEOUT_CYC  (`FORCE_TIMEOUT_MIN * 64'd60 * `CLK_HZ)
`define MS_PER_S           64'd1000
`define MS_TICK_CYC        (`CLK_HZ / `MS_PER_S)
`define PREFAULT_WIN_S     64'd1
`define PREFAULT_WIN_MS    10'((`PREFAULT_WIN_S * `MS_PER_S))

`define ADDR_CTRL          8'h00
`define ADDR_PASSWORD      8'h04
`define ADDR_SCALE         8'h08
`define ADDR_STATUS        8'h0C
`define ADDR_MAXCUR        8'h10
`define ADDR_STAGE_STAT    8'h14
`define ADDR_CNT_CLR       8'h18
`define ADDR_LOG_SEL       8'h1C
`define ADDR_LOG_W0        8'h20
`define ADDR_LOG_W1        8'h24
`define ADDR_LOG_W2        8'h28
`define ADDR_START_CNT     8'h40
`define ADDR_TRIP_CNT      8'h4C
`define ADDR_SET_BASE      8'h80
`define ADDR_PRIMARY       8'hC0
`define ADDR_DLY_TYPE      8'hD0
`define ADDR_CONST_BASE    8'hD4

`define CTRL_FORCE         0
`define CTRL_SCALE         1
`define CTRL_SRC_LSB       2
`define CTRL_GRP_LSB       5
`define CTRL_HARM          7
`define CTRL_IDX_LSB       8

`define SCALE_RST          8'h64
`define SCALE_MIN          8'h0A
`define SCALE_MAX          8'hC8
`define PCT_FULL           8'h64
`define PCT_DIV            32'h64
`define LOG_DEPTH          4'h8

`endif

// file: rtl/ocs_pkg.sv
// Types shared by the overcurrent housekeeping block
package ocs_pkg;
  typedef enum logic [2:0] {
    DLY_DT = 3'b000, DLY_NI = 3'b001, DLY_VI = 3'b010,
    DLY_EI = 3'b011, DLY_LTI = 3'b100, DLY_PARAM = 3'b101
  } delay_type_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_DI = 3'b001, SRC_VI = 3'b010,
    SRC_IND = 3'b011, SRC_VO = 3'b100, SRC_FKEY = 3'b101
  } group_src_t;
  typedef enum logic [2:0] {
    FT_1N = 3'b000, FT_2N = 3'b001, FT_3N = 3'b010, FT_12 = 3'b011,
    FT_23 = 3'b100, FT_31 = 3'b101, FT_123 = 3'b110
  } fault_type_t;
  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
    logic [9:0]  msec;
  } timestamp_t;
  typedef struct packed {
    logic [2:0]  start;
    logic [2:0]  trip;
    fault_type_t ftype;
    logic [7:0]  elapsed_pct;
  } stage_in_t;
  typedef struct packed {
    logic [7:0]  digital;
    logic [7:0]  virt_in;
    logic [7:0]  indicator;
    logic [7:0]  virt_out;
    logic [7:0]  fkey;
  } group_sig_t;
  typedef struct packed {
    timestamp_t  ts;
    fault_type_t ftype;
    logic [1:0]  group;
    logic [7:0]  edly;
    logic [15:0] load;
    logic [15:0] flt;
  } fault_rec_t;
  typedef struct packed {
    logic [15:0] delay;
    logic [15:0] pickup;
  } stage_set_t;
  typedef struct packed {
    logic             valid;
    logic [4:0][15:0] k;
  } coeff_t;
  typedef struct packed {
    logic [31:0]            rdata;
    logic                   unlocked;
    logic                   force_on;
    logic                   scale_en;
    group_src_t             src;
    logic [2:0]             src_idx;
    logic [1:0]             manual_grp;
    logic                   harm;
    logic [7:0]             factor;
    logic [1:0]             grp;
    logic [33:0]            force_cnt;
    logic [2:0]             frc_start;
    logic [2:0]             frc_trip;
    logic [2:0]             eff_start;
    logic [2:0]             eff_trip;
    logic [2:0][15:0]       start_cnt;
    logic [2:0][15:0]       trip_cnt;
    stage_set_t [2:0][3:0]  set;
    delay_type_t            dtype;
    logic [4:0][15:0]       kconst;
    coeff_t                 coeff;
    logic [7:0]             di_s1;
    logic [7:0]             di_s2;
    logic [15:0]            max_cur;
    logic [15:0]            ms_cnt;
    logic [9:0]             win_cnt;
    logic [25:0]            win_sum;
    logic [15:0]            load_avg;
    logic                   in_fault;
    logic                   tripped;
    fault_rec_t             cur;
    fault_rec_t [7:0]       log;
    logic [2:0]             wr_ptr;
    logic [3:0]             log_cnt;
    logic [2:0]             log_sel;
  } state_t;
endpackage : ocs_pkg

// file: rtl/overcurrent_stage_fault_log_scaling.sv
// Setting groups, force flag, counters, fault log and remote pick-up scaling
//
// What this block does
// - Force flag clears after five minutes idle.
// - Status writes accepted only while forcing.
// - Per-stage start and trip counters, clearable.
// - Configuration writes need a valid password.
// - One active group, selectable source signal.
// - Supervise largest of three phase currents.
// - Report pick-up in multiples and primary amps.
// - Constants A-E used only for parameter type.
// - Keep eight newest fault records, drop oldest.
// - Record fault type, peak current, group.
// - Time stamp with date and milliseconds.
// - Pre-fault load is one second average.
// - Elapsed delay in percent, trip is 100.
// - Factor resets to 100, takes 10..200 whether scaling is active or not.
// - Scaling copies group one into group two.
// - Enabling scaling switches to group two.
// - Scaling and group switching never together.
// - Scaling controllable from the register port only.
// - Four setting groups per stage.
`include "ocs_params.svh"

module overcurrent_stage_fault_log_scaling
  import ocs_pkg::*;
#(
  parameter logic [33:0] FORCE_TIMEOUT_CYC = 34'(`FORCE_TIMEOUT_CYC),
  parameter logic [15:0] MS_TICK_CYC       = 16'(`MS_TICK_CYC),
  parameter logic [15:0] PASSWORD          = 16'h5A3C, // Arbitrary value
  parameter logic [15:0] MODE_CURRENT_A    = 16'h0064
)(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output      logic [31:0]           rdata,
  input  wire logic [7:0]            digital_input_n,
  input  wire group_sig_t            group_sigs,
  input  wire logic                  panel_key,
  input  wire stage_in_t             stage_in,
  input  wire logic [2:0][15:0]      phase_current,
  input  wire timestamp_t            timestamp,
  output      logic [1:0]            active_group_number,
  output      logic                  force_flag,
  output      logic                  scaling_active,
  output      logic                  harmonics_included_flag,
  output      logic [2:0]            stage_start,
  output      logic [2:0]            stage_trip,
  output      logic [15:0]           max_phase_current,
  output      logic [2:0][15:0]      active_pickup,
  output      logic [2:0][15:0]      active_delay,
  output      coeff_t                inverse_coeff
);

  state_t s_r;
  state_t s_nxt;

  logic        tick;
  logic        sel_bit;
  logic [7:0]  sel_vec;
  logic [2:0]  start_rise;
  logic [2:0]  trip_rise;
  logic        any_active;
  logic [2:0]  rd_idx;
  fault_rec_t  rd_rec;
  logic        ctrl_ok;
  logic        new_scale;
  group_src_t  new_src;
  logic [3:0]  slot;
  logic [31:0] prim;

  // True when a lies on one of n word slots from base
  function automatic logic in_window(logic [7:0] a, logic [7:0] base,
                                     logic [4:0] n);
    logic [8:0] top;
    top = {1'b0, base} + {2'b00, n, 2'b00};
    return (a[1:0] == 2'b00) && ({1'b0, a} >= {1'b0, base}) &&
           ({1'b0, a} < top);
  endfunction : in_window

  function automatic logic [3:0] slot_of(logic [7:0] a, logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[5:2];
  endfunction : slot_of

  // Saturates: a 200 % factor can exceed the 16-bit pick-up range
  function automatic logic [15:0] scale_pickup(logic [15:0] p,
                                               logic [7:0] f);
    logic [31:0] q;
    q = ({16'h0000, p} * {24'h000000, f}) / `PCT_DIV;
    return (q[31:16] != 16'h0000) ? 16'hFFFF : q[15:0];
  endfunction : scale_pickup

  function automatic logic [15:0] max3(logic [2:0][15:0] v);
    logic [15:0] m;
    m = (v[0] > v[1]) ? v[0] : v[1];
    return (v[2] > m) ? v[2] : m;
  endfunction : max3

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.rdata = 32'h0000_0000;
    tick       = 1'b0;
    sel_bit    = 1'b0;
    sel_vec    = 8'h00;
    start_rise = 3'b000;
    trip_rise  = 3'b000;
    any_active = 1'b0;
    ctrl_ok    = 1'b0;
    new_scale  = 1'b0;
    new_src    = SRC_NONE;
    slot       = 4'h0;
    prim       = 32'h0000_0000;
    rd_idx     = s_r.wr_ptr - 3'h1 - s_r.log_sel;
    rd_rec     = s_r.log[rd_idx];

    // Digital input pins pass two flops before use
    s_nxt.di_s1 = digital_input_n;
    s_nxt.di_s2 = s_r.di_s1;

    s_nxt.max_cur = max3(phase_current);

    if (s_r.ms_cnt == MS_TICK_CYC - 16'h0001)
    begin
      s_nxt.ms_cnt = 16'h0000;
      tick = 1'b1;
    end
    else
      s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;

    // Sliding would cost a 1000-deep buffer; block average instead
    if (tick)
    begin
      if (s_r.win_cnt == `PREFAULT_WIN_MS - 10'h001)
      begin
        s_nxt.load_avg = 16'((s_r.win_sum + 26'(s_r.max_cur)) /
                             26'(`PREFAULT_WIN_MS));
        s_nxt.win_sum = 26'h0000000;
        s_nxt.win_cnt = 10'h000;
      end
      else
      begin
        s_nxt.win_sum = s_r.win_sum + 26'(s_r.max_cur);
        s_nxt.win_cnt = s_r.win_cnt + 10'h001;
      end
    end

    if (s_r.force_on)
    begin
      if (panel_key)
        s_nxt.force_cnt = 34'h0;
      else if (s_r.force_cnt == FORCE_TIMEOUT_CYC - 34'h1)
      begin
        s_nxt.force_on  = 1'b0;
        s_nxt.force_cnt = 34'h0;
      end
      else
        s_nxt.force_cnt = s_r.force_cnt + 34'h1;
    end

    if (wr)
    begin
      unique case (addr)
        `ADDR_PASSWORD:
          s_nxt.unlocked = (wdata[15:0] == PASSWORD);
        `ADDR_CTRL:
        begin
          new_scale = wdata[`CTRL_SCALE];
          new_src   = group_src_t'(wdata[`CTRL_SRC_LSB +: 3]);
          ctrl_ok   = s_r.unlocked && !(new_scale && new_src != SRC_NONE)
                      && (new_src <= SRC_FKEY);
          if (ctrl_ok)
          begin
            s_nxt.scale_en   = new_scale;
            s_nxt.src        = new_src;
            s_nxt.manual_grp = wdata[`CTRL_GRP_LSB +: 2];
            s_nxt.harm       = wdata[`CTRL_HARM];
            s_nxt.src_idx    = wdata[`CTRL_IDX_LSB +: 3];
            s_nxt.force_on   = wdata[`CTRL_FORCE];
            s_nxt.force_cnt  = 34'h0;
          end
        end
        `ADDR_SCALE:
          if (s_r.unlocked && wdata[7:0] >= `SCALE_MIN &&
              wdata[7:0] <= `SCALE_MAX && wdata[31:8] == 24'h0)
            s_nxt.factor = wdata[7:0];
        `ADDR_STAGE_STAT:
          if (s_r.force_on)
          begin
            s_nxt.frc_start = wdata[2:0];
            s_nxt.frc_trip  = wdata[6:4];
          end
        `ADDR_CNT_CLR:
          for (int s = 0; s < 3; s++)
          begin
            if (wdata[s])
              s_nxt.start_cnt[s] = 16'h0000;
            if (wdata[s + 4])
              s_nxt.trip_cnt[s] = 16'h0000;
          end
        `ADDR_LOG_SEL:
          s_nxt.log_sel = wdata[2:0];
        `ADDR_DLY_TYPE:
          if (s_r.unlocked && wdata[2:0] <= DLY_PARAM)
            s_nxt.dtype = delay_type_t'(wdata[2:0]);
        default:
        begin
          if (in_window(addr, `ADDR_SET_BASE, 5'd12) && s_r.unlocked)
          begin
            slot = slot_of(addr, `ADDR_SET_BASE);
            // Group two belongs to the scaler while it runs
            if (!(s_r.scale_en && slot[1:0] == 2'b01))
              s_nxt.set[slot[3:2]][slot[1:0]] = wdata;
          end
          if (in_window(addr, `ADDR_CONST_BASE, 5'd5) && s_r.unlocked)
          begin
            slot = slot_of(addr, `ADDR_CONST_BASE);
            s_nxt.kconst[slot[2:0]] = wdata[15:0];
          end
        end
      endcase
    end

    if (!s_nxt.force_on)
    begin
      s_nxt.frc_start = 3'b000;
      s_nxt.frc_trip  = 3'b000;
    end

    unique case (s_nxt.src)
      SRC_DI:   sel_vec = s_r.di_s2;
      SRC_VI:   sel_vec = group_sigs.virt_in;
      SRC_IND:  sel_vec = group_sigs.indicator;
      SRC_VO:   sel_vec = group_sigs.virt_out;
      SRC_FKEY: sel_vec = group_sigs.fkey;
      default:  sel_vec = 8'h00;
    endcase
    sel_bit = sel_vec[s_nxt.src_idx];
    if (s_nxt.scale_en)
      s_nxt.grp = 2'b01;
    else if (s_nxt.src == SRC_NONE)
      s_nxt.grp = s_nxt.manual_grp;
    else
      s_nxt.grp = sel_bit ? 2'b01 : 2'b00;

    if (s_nxt.scale_en)
      for (int s = 0; s < 3; s++)
      begin
        s_nxt.set[s][1].delay  = s_nxt.set[s][0].delay;
        s_nxt.set[s][1].pickup =
          scale_pickup(s_nxt.set[s][0].pickup, s_nxt.factor);
      end

    s_nxt.coeff.valid = (s_nxt.dtype == DLY_PARAM);
    s_nxt.coeff.k = s_nxt.coeff.valid ? s_nxt.kconst : '0;

    s_nxt.eff_start = s_nxt.force_on ? s_nxt.frc_start : stage_in.start;
    s_nxt.eff_trip  = s_nxt.force_on ? s_nxt.frc_trip  : stage_in.trip;
    start_rise = s_nxt.eff_start & ~s_r.eff_start;
    trip_rise  = s_nxt.eff_trip & ~s_r.eff_trip;
    // Increment placed after clear so a new event is never lost
    for (int s = 0; s < 3; s++)
    begin
      if (start_rise[s])
        s_nxt.start_cnt[s] = s_nxt.start_cnt[s] + 16'h0001;
      if (trip_rise[s])
        s_nxt.trip_cnt[s] = s_nxt.trip_cnt[s] + 16'h0001;
    end

    any_active = (|s_nxt.eff_start) || (|s_nxt.eff_trip);
    if (any_active && !s_r.in_fault)
    begin
      s_nxt.in_fault  = 1'b1;
      s_nxt.tripped   = 1'b0;
      s_nxt.cur.ts    = timestamp;
      s_nxt.cur.ftype = stage_in.ftype;
      s_nxt.cur.group = s_r.grp;
      s_nxt.cur.flt   = s_r.max_cur;
      s_nxt.cur.load  = s_r.load_avg;
      s_nxt.cur.edly  = 8'h00;
    end
    else if (s_r.in_fault)
    begin
      if (s_r.max_cur > s_r.cur.flt)
        s_nxt.cur.flt = s_r.max_cur;
      if (any_active)
        s_nxt.cur.ftype = stage_in.ftype;
      if (!s_r.tripped && stage_in.elapsed_pct > s_r.cur.edly)
        s_nxt.cur.edly = (stage_in.elapsed_pct > `PCT_FULL) ?
                         `PCT_FULL : stage_in.elapsed_pct;
    end
    if (any_active && (|s_nxt.eff_trip) && !s_r.tripped)
    begin
      s_nxt.tripped   = 1'b1;
      s_nxt.cur.ts    = timestamp;
      s_nxt.cur.edly  = `PCT_FULL;
    end
    if (!any_active && s_r.in_fault)
    begin
      s_nxt.in_fault = 1'b0;
      s_nxt.log[s_r.wr_ptr] = s_nxt.cur;
      s_nxt.wr_ptr = s_r.wr_ptr + 3'h1;
      if (s_r.log_cnt != `LOG_DEPTH)
        s_nxt.log_cnt = s_r.log_cnt + 4'h1;
    end

    if (rd)
    begin
      unique case (addr)
        `ADDR_CTRL:
          s_nxt.rdata = {21'h0, s_r.src_idx, s_r.harm, s_r.manual_grp,
                         s_r.src, s_r.scale_en, s_r.force_on};
        `ADDR_SCALE:      s_nxt.rdata = {24'h0, s_r.factor};
        `ADDR_STATUS:
          s_nxt.rdata = {23'h0, s_r.in_fault, s_r.log_cnt, s_r.unlocked,
                         s_r.scale_en, s_r.grp};
        `ADDR_MAXCUR:     s_nxt.rdata = {16'h0, s_r.max_cur};
        `ADDR_STAGE_STAT:
          s_nxt.rdata = {25'h0, s_r.eff_trip, 1'b0, s_r.eff_start};
        `ADDR_LOG_SEL:    s_nxt.rdata = {29'h0, s_r.log_sel};
        `ADDR_LOG_W0:     s_nxt.rdata = rd_rec.ts[31:0];
        `ADDR_LOG_W1:
          s_nxt.rdata = {3'h0, rd_rec.ftype, rd_rec.group, rd_rec.edly,
                         rd_rec.ts[47:32]};
        `ADDR_LOG_W2:     s_nxt.rdata = {rd_rec.load, rd_rec.flt};
        `ADDR_DLY_TYPE:   s_nxt.rdata = {29'h0, s_r.dtype};
        default:
        begin
          if (in_window(addr, `ADDR_START_CNT, 5'd3))
          begin
            slot = slot_of(addr, `ADDR_START_CNT);
            s_nxt.rdata = {16'h0, s_r.start_cnt[slot[1:0]]};
          end
          else if (in_window(addr, `ADDR_TRIP_CNT, 5'd3))
          begin
            slot = slot_of(addr, `ADDR_TRIP_CNT);
            s_nxt.rdata = {16'h0, s_r.trip_cnt[slot[1:0]]};
          end
          else if (in_window(addr, `ADDR_SET_BASE, 5'd12))
          begin
            slot = slot_of(addr, `ADDR_SET_BASE);
            s_nxt.rdata = s_r.set[slot[3:2]][slot[1:0]];
          end
          else if (in_window(addr, `ADDR_PRIMARY, 5'd3))
          begin
            slot = slot_of(addr, `ADDR_PRIMARY);
            prim = ({16'h0, s_r.set[slot[1:0]][s_r.grp].pickup} *
                    {16'h0, MODE_CURRENT_A}) / `PCT_DIV;
            s_nxt.rdata = prim;
          end
          else if (in_window(addr, `ADDR_CONST_BASE, 5'd5))
          begin
            slot = slot_of(addr, `ADDR_CONST_BASE);
            s_nxt.rdata = {16'h0, s_r.kconst[slot[2:0]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.factor <= `SCALE_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata                   = s_r.rdata;
  assign active_group_number     = s_r.grp;
  assign force_flag              = s_r.force_on;
  assign scaling_active          = s_r.scale_en;
  assign harmonics_included_flag = s_r.harm;
  assign stage_start             = s_r.eff_start;
  assign stage_trip              = s_r.eff_trip;
  assign max_phase_current       = s_r.max_cur;
  assign inverse_coeff           = s_r.coeff;

  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_active
      assign active_pickup[g] = s_r.set[g][s_r.grp].pickup;
      assign active_delay[g]  = s_r.set[g][s_r.grp].delay;
    end
  endgenerate

endmodule : overcurrent_stage_fault_log_scaling

// file: bench/ocs_props.sv
// Port assertions for the overcurrent housekeeping block
`include "ocs_params.svh"

module ocs_props
  import ocs_pkg::*;
#(
  parameter logic [33:0] FORCE_TIMEOUT_CYC = 34'h0C8
)(
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic [7:0]       addr,
  input wire logic [31:0]      wdata,
  input wire logic             wr,
  input wire logic             panel_key,
  input wire stage_in_t        stage_in,
  input wire logic [2:0][15:0] phase_current,
  input wire logic [1:0]       active_group_number,
  input wire logic             force_flag,
  input wire logic             scaling_active,
  input wire logic             harmonics_included_flag,
  input wire logic [2:0]       stage_start,
  input wire logic [15:0]      max_phase_current,
  input wire coeff_t           inverse_coeff
);
  logic [15:0] peak;
  logic [33:0] idle_cnt_r;
  logic        ctrl_wr;

  assign ctrl_wr = wr && (addr == `ADDR_CTRL);

  always_comb
  begin
    peak = phase_current[0];
    if (phase_current[1] > peak)
      peak = phase_current[1];
    if (phase_current[2] > peak)
      peak = phase_current[2];
  end

  // Restarts cover the ones that rearm the force timeout, plus any control write
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      idle_cnt_r <= '0;
    else if (!force_flag || panel_key || ctrl_wr)
      idle_cnt_r <= '0;
    else
      idle_cnt_r <= idle_cnt_r + 34'h1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_scale_group: assert property (
    scaling_active |-> active_group_number == 2'h1)
    else $error("scaling outside group two");
  a_max_phase: assert property (
    $past(rstn) |-> max_phase_current == $past(peak))
    else $error("max phase current wrong");
  a_coeff_gate: assert property (
    !inverse_coeff.valid |-> inverse_coeff.k == '0)
    else $error("constants leak without parameter type");
  a_status_follow: assert property (
    $past(rstn) && !$past(force_flag) && !force_flag
    |-> stage_start == $past(stage_in.start))
    else $error("status differs from stage while not forcing");
  a_force_expire: assert property (
    idle_cnt_r <= FORCE_TIMEOUT_CYC + 34'h3)
    else $error("force flag outlived timeout");
  a_force_cause: assert property (
    $rose(force_flag) |-> $past(ctrl_wr) && $past(wdata[0]))
    else $error("force set without control write");
  a_scale_cause: assert property (
    $rose(scaling_active) |-> $past(ctrl_wr && wdata[`CTRL_SCALE]))
    else $error("scaling set without control write");
  a_scale_alone: assert property (
    $rose(scaling_active) |-> $past(wdata[4:2]) == 3'h0)
    else $error("scaling set beside group source");
  a_harm_cause: assert property (
    $changed(harmonics_included_flag) |-> $past(ctrl_wr))
    else $error("harmonics flag moved without write");

  c_scaling: cover property ($rose(scaling_active));
  c_force_end: cover property ($fell(force_flag));
  c_coeff: cover property ($rose(inverse_coeff.valid));
endmodule : ocs_props

bind overcurrent_stage_fault_log_scaling ocs_props #(
  .FORCE_TIMEOUT_CYC(FORCE_TIMEOUT_CYC)
) u_props (
  .clk, .rstn, .addr, .wdata, .wr, .panel_key, .stage_in, .phase_current,
  .active_group_number, .force_flag, .scaling_active,
  .harmonics_included_flag, .stage_start, .max_phase_current,
  .inverse_coeff
);

// file: bench/scada_host.sv
// Station controller model mastering the register port
`include "ocs_params.svh"

module scada_host
(
  input  wire logic        clk,
  output      logic [7:0]  addr,
  output      logic [31:0] wdata,
  output      logic        wr,
  output      logic        rd,
  input  wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr = 8'hFF;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    // Released lines must not keep looking valid
    addr  <= ~a;
    wdata <= ~v;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  // Factor travels as a plain integer, one unit per percent
  task automatic set_factor(input int pct);
    wr_reg(`ADDR_SCALE, 32'(pct));
  endtask : set_factor
endmodule : scada_host

// file: bench/overcurrent_stage_fault_log_scaling_tb.sv
// Self-checking bench for the overcurrent housekeeping block
`include "ocs_params.svh"

module overcurrent_stage_fault_log_scaling_tb;
  import ocs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk;
  logic             rstn;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             wr;
  logic             rd;
  logic [31:0]      rdata;
  logic [7:0]       din;
  group_sig_t       gsig;
  logic             panel_key;
  stage_in_t        sin;
  logic [2:0][15:0] phase;
  timestamp_t       ts;
  logic [1:0]       grp;
  logic             force_flag;
  logic             scal;
  logic             harm;
  logic [2:0]       st_start;
  logic [2:0]       st_trip;
  logic [2:0][15:0] pick;
  logic [2:0][15:0] dly;
  logic [15:0]      mpc;
  coeff_t           coeff;
  logic [31:0]      d;
  int               miscompares;
  int               n_checks;
  int               cyc;

  scada_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  overcurrent_stage_fault_log_scaling #(
    .FORCE_TIMEOUT_CYC(34'h0C8), .MS_TICK_CYC(16'h0004)
  ) u_dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .digital_input_n(din), .group_sigs(gsig),
    .panel_key(panel_key), .stage_in(sin), .phase_current(phase),
    .timestamp(ts), .active_group_number(grp), .force_flag(force_flag),
    .scaling_active(scal), .harmonics_included_flag(harm),
    .stage_start(st_start), .stage_trip(st_trip), .max_phase_current(mpc),
    .active_pickup(pick), .active_delay(dly), .inverse_coeff(coeff));

  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    u_host.wr_reg(a, v);
  endtask : wreg

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    u_host.rd_reg(a, v);
    chk(v, e);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Bounds a hang well past the longest expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    rstn = 1'b0;
    din = 8'h0;
    gsig = '0;
    panel_key = 1'b0;
    sin = '0;
    phase = {3{16'h0080}};
    ts = '0;
    idle(16);
    rstn <= 1'b1;
    wreg(`ADDR_CTRL, 32'h82);
    rdchk(`ADDR_STATUS, 32'h0);
    wreg(`ADDR_PASSWORD, 32'h5A3C);
    rdchk(`ADDR_STATUS, 32'h8);
    wreg(8'hF0, 32'h1);
    rdchk(8'hF0, 32'h0);
    wreg(`ADDR_CTRL, 32'hE0);
    idle(2);
    chk(grp, 2'h3);
    chk(harm, 1'b1);
    for (int s = 1; s <= 5; s++)
    begin
      wreg(`ADDR_CTRL, 32'(((s + 1) << 8) | (s << 2)));
      gsig <= group_sig_t'(40'h1 << ((5 - s) * 8 + s + 1));
      din <= (s == 1) ? 8'h04 : 8'h00;
      idle(4);
      chk(grp, 2'h1);
      gsig <= '0;
      din <= 8'h0;
      idle(4);
      chk(grp, 2'h0);
    end
    wreg(`ADDR_CTRL, 32'h0);
    wreg(8'h80, 32'h0010_00C8);
    rdchk(8'h80, 32'h0010_00C8);
    wreg(8'h8C, 32'h0000_0001);
    rdchk(8'h8C, 32'h0000_0001);
    rdchk(`ADDR_PRIMARY, 32'h0000_00C8);
    u_host.set_factor(9);
    rdchk(`ADDR_SCALE, 32'h64);
    u_host.set_factor(201);
    rdchk(`ADDR_SCALE, 32'h64);
    u_host.set_factor(150);
    rdchk(`ADDR_SCALE, 32'h96);
    wreg(`ADDR_CTRL, 32'h6);
    idle(2);
    chk(scal, 1'b0);
    wreg(`ADDR_CTRL, 32'h2);
    idle(2);
    chk(scal, 1'b1);
    chk(grp, 2'h1);
    rdchk(8'h84, 32'h0010_012C);
    chk(pick[0], 16'h012C);
    chk(dly[0], 16'h0010);
    wreg(8'h80, 32'h0010_0100);
    wreg(8'h84, 32'h0);
    rdchk(8'h84, 32'h0010_0180);
    u_host.set_factor(200);
    rdchk(8'h84, 32'h0010_0200);
    u_host.set_factor(10);
    rdchk(8'h84, 32'h0010_0019);
    rdchk(`ADDR_PRIMARY, 32'h0000_0019);
    wreg(`ADDR_CTRL, 32'h0);
    idle(2);
    chk(grp, 2'h0);
    wreg(`ADDR_CONST_BASE, 32'h1234);
    wreg(`ADDR_DLY_TYPE, 32'h6);
    rdchk(`ADDR_DLY_TYPE, 32'h0);
    wreg(`ADDR_DLY_TYPE, 32'h5);
    idle(2);
    chk(coeff.valid, 1'b1);
    chk(coeff.k[0], 16'h1234);
    wreg(`ADDR_DLY_TYPE, 32'h1);
    idle(2);
    chk(coeff.k[0], 16'h0);
    wreg(`ADDR_STAGE_STAT, 32'h41);
    wreg(`ADDR_CTRL, 32'h1);
    idle(2);
    chk(st_start, 3'h0);
    wreg(`ADDR_STAGE_STAT, 32'h41);
    idle(2);
    chk({st_trip, st_start}, 6'h21);
    rdchk(`ADDR_START_CNT, 32'h1);
    rdchk(8'h54, 32'h1);
    wreg(`ADDR_CNT_CLR, 32'h41);
    rdchk(`ADDR_START_CNT, 32'h0);
    rdchk(8'h54, 32'h0);
    idle(150);
    panel_key <= 1'b1;
    idle(1);
    panel_key <= 1'b0;
    idle(150);
    chk(force_flag, 1'b1);
    idle(60);
    chk(force_flag, 1'b0);
    chk(st_start, 3'h0);
    while (cyc < 9000)
      idle(1);
    ts <= '{12'h7E8, 4'h3, 5'h09, 5'h0C, 6'h1E, 6'h2D, 10'h1F4};
    phase <= {16'h0200, 16'h0300, 16'h0100};
    sin <= '{3'b010, 3'b000, FT_23, 8'h96};
    idle(10);
    sin <= '0;
    idle(5);
    // Forced episode before this one already left a record
    rdchk(`ADDR_STATUS, 32'h28);
    wreg(`ADDR_LOG_SEL, 32'h0);
    rdchk(`ADDR_LOG_W0, ts[31:0]);
    rdchk(`ADDR_LOG_W1, {3'h0, FT_23, 2'h0, 8'h64, ts[47:32]});
    rdchk(`ADDR_LOG_W2, 32'h0080_0300);
    for (int i = 0; i < 8; i++)
    begin
      sin <= '{3'b001, 3'b000, fault_type_t'(i % 7), 8'(10 + i)};
      idle(6);
      sin <= '0;
      idle(4);
    end
    rdchk(`ADDR_STATUS, 32'h88);
    rdchk(`ADDR_START_CNT, 32'h8);
    rdchk(`ADDR_MAXCUR, 32'h0300);
    chk(mpc, 16'h0300);
    for (int j = 0; j < 8; j++)
    begin
      wreg(`ADDR_LOG_SEL, 32'(j));
      u_host.rd_reg(`ADDR_LOG_W1, d);
      chk(d[28:16], {3'((7 - j) % 7), 2'h0, 8'(17 - j)});
    end
    stop_test();
  end
endmodule : overcurrent_stage_fault_log_scaling_tb
